/* File: return_and_setup_instr_exec_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module return_and_setup_instr_exec_bench;
    logic sys_clk = 0, reset_n = 0, instr_valid = 0;
    logic [12:0] instr = 13'h0000;
    logic [11:0] stack_top = 12'h123, pc;
    logic [7:0] work_register, setup_reg;
    logic instr_ready, global_irq_enable, stack_pop, unhandled;
    int failures = 0, n_checks = 0;
    rsx_exec i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .instr_valid(instr_valid), .instr(instr),
        .stack_top(stack_top), .instr_ready(instr_ready), .pc(pc), .work_register(work_register),
        .setup_reg(setup_reg), .global_irq_enable(global_irq_enable), .stack_pop(stack_pop), .unhandled(unhandled));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    initial forever #25 sys_clk = ~sys_clk;
    task chk(input string n, input logic [11:0] s, input logic [11:0] e);
        n_checks++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // One issue, then look once the answering edge has landed
    task op(input logic [12:0] c);
        @(posedge sys_clk);
        instr <= c;
        instr_valid <= 1'b1;
        @(posedge sys_clk);
        instr_valid <= 1'b0;
        #1;
    endtask
    task report_and_stop;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_setup;
        op(13'h0D5A);
        chk("lret work", {4'h0, work_register}, 12'h05A);
        chk("lret pc", pc, 12'h123);
        chk("lret bubble", {stack_pop, instr_ready}, 12'h002);
        op(13'h0002);
        chk("wset setup", {4'h0, setup_reg}, 12'h05A);
        chk("wset pc", pc, 12'h124);
        op(13'h0DA5);
        op(13'h0003);
        chk("rset work", {4'h0, work_register}, 12'h05A);
        $display("setup test done");
    endtask
    task t_returns;
        @(posedge sys_clk);
        stack_top <= 12'hABC;
        op(13'h000D);
        chk("iret pc", pc, 12'hABC);
        chk("iret gie", {11'h0, global_irq_enable}, 12'h001);
        @(posedge sys_clk);
        stack_top <= 12'h7F0;
        op(13'h000E);
        chk("ret pc", pc, 12'h7F0);
        chk("ret work", {4'h0, work_register}, 12'h05A);
        $display("return test done");
    endtask
    task t_idle;
        op(13'h0000);
        chk("idle pc", pc, 12'h7F1);
        chk("idle regs", {work_register, setup_reg[3:0]}, 12'h5AA);
        chk("idle pop", {stack_pop, unhandled}, 12'h000);
        op(13'h1FFF);
        chk("other pc", pc, 12'h7F2);
        chk("other flag", {stack_pop, unhandled}, 12'h001);
        $display("idle test done");
    endtask
    // A request held through the bubble must wait for ready
    task t_refuse;
        @(posedge sys_clk);
        stack_top <= 12'h456;
        instr <= 13'h000E;
        instr_valid <= 1'b1;
        @(posedge sys_clk);
        instr <= 13'h0D33;
        @(posedge sys_clk);
        #1;
        chk("bubble work", {4'h0, work_register}, 12'h05A);
        chk("bubble pc", pc, 12'h456);
        chk("bubble ready", {11'h0, instr_ready}, 12'h001);
        @(posedge sys_clk);
        instr_valid <= 1'b0;
        #1;
        chk("held lret work", {4'h0, work_register}, 12'h033);
        chk("held lret pc", pc, 12'h456);
        $display("refuse test done");
    endtask
    // Mid-run reset must clear the enable that the irq return set
    task t_reset;
        @(posedge sys_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        #1;
        chk("rst gie", {11'h0, global_irq_enable}, 12'h000);
        chk("rst pc", pc, 12'h000);
        chk("rst ready", {11'h0, instr_ready}, 12'h001);
        op(13'h0003);
        chk("rst rset work", {4'h0, work_register}, 12'h0FF);
        $display("reset test done");
    endtask
    // Whole run is well under 100 cycles
    initial begin
        #20000;
        failures++;
        report_and_stop;
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        #1;
        chk("rst setup", {4'h0, setup_reg}, 12'h0FF);
        t_setup;
        t_returns;
        t_idle;
        t_refuse;
        t_reset;
        report_and_stop;
    end
endmodule
`default_nettype wire

/* File: rsx_decode.v */
`timescale 1ns/10ps
`default_nettype none
`include "rsx_defines.vh"
// Pure opcode classifier; no state
module rsx_decode (
    input wire [`RSX_INSTR_W-1:0] instr,
    output reg [`RSX_CLS_W-1:0] cls
);
    // ----------------------------------------
    // Class lookup
    // ----------------------------------------
    always @* begin
        if (instr == `RSX_OP_IDLE)
            cls = `RSX_CLS_IDLE;
        else if (instr == `RSX_OP_WSET)
            cls = `RSX_CLS_WSET;
        else if (instr == `RSX_OP_RSET)
            cls = `RSX_CLS_RSET;
        else if (instr == `RSX_OP_IRET)
            cls = `RSX_CLS_IRET;
        else if (instr == `RSX_OP_RET)
            cls = `RSX_CLS_RET;
        else if ((instr & `RSX_LRET_MASK) == `RSX_LRET_CODE)
            cls = `RSX_CLS_LRET;
        else
            cls = `RSX_CLS_OTHER;
    end
endmodule
`default_nettype wire

/* File: rsx_defines.vh */
`ifndef RSX_DEFINES_VH
`define RSX_DEFINES_VH
// ----------------------------------------
// Word widths
// ----------------------------------------
`define RSX_INSTR_W 13
`define RSX_DATA_W 8
`define RSX_PC_W 12
// ----------------------------------------
// Decoded instruction classes
// ----------------------------------------
`define RSX_CLS_W 3
`define RSX_CLS_IDLE 3'h0
`define RSX_CLS_WSET 3'h1
`define RSX_CLS_RSET 3'h2
`define RSX_CLS_IRET 3'h3
`define RSX_CLS_LRET 3'h4
`define RSX_CLS_RET 3'h5
`define RSX_CLS_OTHER 3'h7
// ----------------------------------------
// Opcode values (chosen encodings)
// ----------------------------------------
`define RSX_OP_IDLE 13'h0000
`define RSX_OP_WSET 13'h0002
`define RSX_OP_RSET 13'h0003
`define RSX_OP_IRET 13'h000D
`define RSX_OP_RET 13'h000E
`define RSX_LRET_MASK 13'h1F00
`define RSX_LRET_CODE 13'h0D00
// ----------------------------------------
// Reset values and program counter step
// ----------------------------------------
`define RSX_SETUP_RST 8'hFF
`define RSX_WORK_RST 8'h00
`define RSX_PC_RST 12'h000
`define RSX_PC_STEP 12'h001
`endif

/* File: rsx_exec.v */
`timescale 1ns/10ps
`default_nettype none
`include "rsx_defines.vh"
module rsx_exec (
    input wire sys_clk,
    input wire reset_n,
    input wire instr_valid,
    input wire [`RSX_INSTR_W-1:0] instr,
    input wire [`RSX_PC_W-1:0] stack_top,
    output reg instr_ready,
    output reg [`RSX_PC_W-1:0] pc,
    output reg [`RSX_DATA_W-1:0] work_register,
    output reg [`RSX_DATA_W-1:0] setup_reg,
    output reg global_irq_enable,
    output reg stack_pop,
    output reg unhandled
);
    // ----------------------------------------
    // State codes
    // ----------------------------------------
    // Run takes instructions; flush is the second cycle of a return
    localparam ST_RUN = 1'b0;
    localparam ST_FLUSH = 1'b1;

    // ----------------------------------------
    // Internal signals
    // ----------------------------------------
    // Combinational helpers
    wire [`RSX_CLS_W-1:0] cls;
    wire issue_ok;
    wire is_return;
    wire [`RSX_PC_W-1:0] pc_step;
    wire [`RSX_DATA_W-1:0] imm_byte;

    // Sequencer state
    reg state;

    // Next values, one per register
    reg next_state;
    reg [`RSX_PC_W-1:0] next_pc;
    reg [`RSX_DATA_W-1:0] next_work;
    reg [`RSX_DATA_W-1:0] next_setup;
    reg next_gie;
    reg next_pop;
    reg next_ready;
    reg next_unh;

    // ----------------------------------------
    // Opcode classifier
    // ----------------------------------------
    // Kept apart so encodings can move without touching the sequencing
    rsx_decode u_decode (
        .instr(instr),
        .cls(cls)
    );

    // ----------------------------------------
    // Issue qualifiers
    // ----------------------------------------
    // Only the run state accepts a word; the flush cycle refuses it
    assign issue_ok = instr_valid && (state == ST_RUN);
    // All three return forms share the pop and the bubble
    assign is_return = (cls == `RSX_CLS_IRET) || (cls == `RSX_CLS_LRET) || (cls == `RSX_CLS_RET);
    // Sequential address; wraps silently at the top of program space
    assign pc_step = pc + `RSX_PC_STEP;
    // The literal return carries its value in the low byte
    assign imm_byte = instr[`RSX_DATA_W-1:0];

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    // Returns spend a second cycle as a fetch bubble; nothing is taken then
    always @* begin
        next_state = state;
        next_ready = 1'b1;
        case (state)
            ST_RUN: begin
                if (issue_ok && is_return) begin
                    next_state = ST_FLUSH;
                    next_ready = 1'b0;
                end
            end
            ST_FLUSH: begin
                // Prefetched word is dropped here
                next_state = ST_RUN;
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
    end

    // ----------------------------------------
    // Program counter
    // ----------------------------------------
    // Returns reload from the stack; everything else steps by one
    always @* begin
        next_pc = pc;
        if (issue_ok) begin
            case (cls)
                `RSX_CLS_IDLE: begin
                    next_pc = pc_step;
                end
                `RSX_CLS_IRET: begin
                    next_pc = stack_top;
                end
                `RSX_CLS_LRET: begin
                    next_pc = stack_top;
                end
                `RSX_CLS_RET: begin
                    next_pc = stack_top;
                end
                default: begin
                    // Setup moves and foreign opcodes step as well
                    next_pc = pc_step;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Work register
    // ----------------------------------------
    // Only the setup read and the literal return write it
    always @* begin
        next_work = work_register;
        if (issue_ok) begin
            case (cls)
                `RSX_CLS_RSET: begin
                    next_work = setup_reg;
                end
                `RSX_CLS_LRET: begin
                    next_work = imm_byte;
                end
                default: begin
                    // Plain and interrupt returns leave it alone
                    next_work = work_register;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Timer setup register
    // ----------------------------------------
    // Field meaning lives in the timer; this block only moves the byte
    always @* begin
        next_setup = setup_reg;
        if (issue_ok && (cls == `RSX_CLS_WSET)) begin
            next_setup = work_register;
        end
    end

    // ----------------------------------------
    // Interrupt enable and side pulses
    // ----------------------------------------
    // Enable is only ever set here; clearing belongs to the interrupt logic
    always @* begin
        next_gie = global_irq_enable;
        next_pop = 1'b0;
        next_unh = 1'b0;
        if (issue_ok) begin
            if (cls == `RSX_CLS_IRET) begin
                next_gie = 1'b1;
            end
            if (is_return) begin
                next_pop = 1'b1;
            end
            if (cls == `RSX_CLS_OTHER) begin
                next_unh = 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // Sequencer state and ready; ready mirrors run so it leaves a flop
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            state <= ST_RUN;
            instr_ready <= 1'b1;
        end else begin
            state <= next_state;
            instr_ready <= next_ready;
        end
    end

    // Program counter
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            pc <= `RSX_PC_RST;
        end else begin
            pc <= next_pc;
        end
    end

    // Data registers; both come up at their chosen reset values
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            work_register <= `RSX_WORK_RST;
            setup_reg <= `RSX_SETUP_RST;
        end else begin
            work_register <= next_work;
            setup_reg <= next_setup;
        end
    end

    // Enable and pulses; a reset drops any pulse in flight
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            global_irq_enable <= 1'b0;
            stack_pop <= 1'b0;
            unhandled <= 1'b0;
        end else begin
            global_irq_enable <= next_gie;
            stack_pop <= next_pop;
            unhandled <= next_unh;
        end
    end
endmodule
`default_nettype wire

/* File: rsx_exec_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module rsx_exec_chk (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic instr_valid,
    input wire logic [12:0] instr,
    input wire logic [11:0] stack_top,
    input wire logic instr_ready,
    input wire logic [11:0] pc,
    input wire logic [7:0] work_register,
    input wire logic [7:0] setup_reg,
    input wire logic global_irq_enable,
    input wire logic stack_pop,
    input wire logic unhandled
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // Taken only while ready, a stall would hide a slip
    wire logic take = instr_valid && instr_ready;
    // Any of the three return forms
    wire logic ret_any = instr == 13'h000D || instr == 13'h000E || instr[12:8] == 5'h0D;
    setup_write_a: assert property (take && instr == 13'h0002 |=>
        setup_reg == $past(work_register) && pc == $past(pc) + 12'h001) else $error("setup write wrong");
    setup_read_a: assert property (take && instr == 13'h0003 |=>
        work_register == $past(setup_reg) && instr_ready) else $error("setup read wrong");
    irq_return_a: assert property (take && instr == 13'h000D |=>
        pc == $past(stack_top) && global_irq_enable && !instr_ready ##1 instr_ready) else $error("irq return wrong");
    lit_return_a: assert property (take && instr[12:8] == 5'h0D |=>
        work_register == $past(instr[7:0]) && pc == $past(stack_top)) else $error("literal return wrong");
    plain_return_a: assert property (take && instr == 13'h000E |=>
        $stable(work_register) && stack_pop && pc == $past(stack_top) ##1 !stack_pop) else $error("return wrong");
    idle_step_a: assert property (take && instr == 13'h0000 |=>
        pc == $past(pc) + 12'h001 && $stable(setup_reg) && $stable(work_register) && !stack_pop)
        else $error("idle wrong");
    // The bubble must refuse whatever is offered and then reopen
    bubble_hold_a: assert property (!instr_ready |=>
        $stable(pc) && $stable(work_register) && $stable(setup_reg) && !stack_pop && instr_ready)
        else $error("bubble not held");
    single_ready_a: assert property (instr_ready && !(take && ret_any) |=> instr_ready)
        else $error("ready dropped");
    cover property (take && instr == 13'h000D);
    cover property (take && instr[12:8] == 5'h0D);
    cover property (take && instr == 13'h0002);
    cover property (!instr_ready && instr_valid);
endmodule
bind rsx_exec rsx_exec_chk i_chk (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .instr_valid(instr_valid),
    .instr(instr),
    .stack_top(stack_top),
    .instr_ready(instr_ready),
    .pc(pc),
    .work_register(work_register),
    .setup_reg(setup_reg),
    .global_irq_enable(global_irq_enable),
    .stack_pop(stack_pop),
    .unhandled(unhandled)
);
`default_nettype wire
